// ==== rtl/ifbm_pkg.sv ====
// Shared constants, register map and state encoding of the instruction fetch bus master.
// Assumes a single clock domain shared by the core side and the local bus.
package ifbm_pkg;

  // Bus and line geometry.
  localparam int ADDR_W     = 30;
  localparam int DATA_W     = 64;
  localparam int WORD_W     = 32;
  localparam int LINE_WORDS = 8;
  localparam int IDX_W      = 3;
  localparam int TAG_W      = ADDR_W - IDX_W;

  // Line size codes on the two driven size bits.
  localparam logic [1:0] SIZE_4W = 2'h1;
  localparam logic [1:0] SIZE_8W = 2'h2;

  // Beats per line for each size and slave width.
  localparam logic [3:0] BEATS_4W_64 = 4'h2;
  localparam logic [3:0] BEATS_4W_32 = 4'h4;
  localparam logic [3:0] BEATS_8W_64 = 4'h4;
  localparam logic [3:0] BEATS_8W_32 = 4'h8;

  // Register map and field positions.
  localparam int         RADDR_W        = 4;
  localparam logic [3:0] REG_CORE_CFG   = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h4;
  localparam int         CFG_NCSIZE_BIT = 0;
  localparam int         CFG_NOFILL_BIT = 1;
  localparam int         CFG_PRIO_LSB   = 2;
  localparam logic [1:0] CFG_PRIO_RESET = 2'h0;
  localparam int         ST_BUSY_BIT    = 0;
  localparam int         ST_ERR_BIT     = 1;
  localparam int         ST_SLVBSY_BIT  = 2;
  localparam int         ST_VALID_LSB   = 8;

  // Fetch sequencer states, Gray coded along idle, request, data, done.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_REQ  = 2'h1,
    ST_DATA = 2'h3,
    ST_DONE = 2'h2
  } ifbm_state_t;

endpackage

// ==== rtl/ifbm_fill_buf.sv ====
// Line fill buffer: eight instruction words with a valid bit each.
// Assumes writes come from the bus sequencer on the same clock; read port is combinational.
`timescale 1ns/1ps
module ifbm_fill_buf
  import ifbm_pkg::*;
(
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  // Write side
  input  wire logic                         clr,
  input  wire logic                         wr_en,
  input  wire logic                         wr_wide,
  input  wire logic [IDX_W-1:0]             wr_idx,
  input  wire logic [DATA_W-1:0]            wr_data,
  // Read side
  input  wire logic [IDX_W-1:0]             rd_idx,
  output logic      [WORD_W-1:0]            rd_word,
  output logic      [LINE_WORDS*WORD_W-1:0] line_flat,
  output logic      [LINE_WORDS-1:0]        valid
);

  logic [WORD_W-1:0] word_reg [LINE_WORDS];

  // Each entry is placed by the beat's index, so any return order fills correctly.
  for (genvar i = 0; i < LINE_WORDS; i++) begin : g_word
    logic hit;
    logic [WORD_W-1:0] din;
    localparam logic [IDX_W-1:0] IDX = IDX_W'(i);
    // A doubleword beat covers the even/odd pair; a word beat arrives on the upper lane.
    assign hit = wr_en && (wr_wide ? (wr_idx[IDX_W-1:1] == IDX[IDX_W-1:1]) : (wr_idx == IDX));
    assign din = (wr_wide && IDX[0]) ? wr_data[WORD_W-1:0] : wr_data[DATA_W-1:WORD_W];
    // Storage and valid flag of one word.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        word_reg[i] <= '0;
        valid[i]    <= 1'b0;
      end else if (clr) begin
        valid[i] <= 1'b0;
      end else if (hit) begin
        word_reg[i] <= din;
        valid[i]    <= 1'b1;
      end
    end
    assign line_flat[i*WORD_W +: WORD_W] = word_reg[i];
  end

  // Read port for buffer hits.
  assign rd_word = word_reg[rd_idx];

endmodule

// ==== rtl/ifbm_fetch_master.sv ====
// Instruction fetch bus master: issues line reads, fills the line buffer, bypasses the
// target word, serves buffer hits and writes finished cacheable lines to the cache.
// Assumes the local bus runs on ref_clk, so bus inputs need no synchroniser.
//
// Contract
// - Only reads memory; 30-bit address out, 64-bit read data in.
// - Works with 64-bit or 32-bit slaves, one beat per cycle.
// - Request raised on cache miss or non-cacheable access.
// - Address holds word bits only; arbiter ties two low bits to zero.
// - Requests are aligned doublewords; no byte enables used.
// - Two size bits encode four or eight words; upper bits tied zero.
// - Cacheable requests always use eight-word line size.
// - Cacheable and user storage attributes driven with each request.
// - Two-bit priority driven for arbiter selection.
// - Unacknowledged request can be aborted on branch or interrupt.
// - Beats arrive in any order, placed by word index.
// - Target instruction bypassed to fetch stage on arrival.
// - Later fetches hitting the fill buffer are served at hit speed.
// - Non-cacheable line size chosen by software size bit.
// - Non-cacheable lines stay only in the fill buffer.
// - Full cacheable line written to cache unless no-allocate set.
// - Error-free cacheable touch-fetched lines always written to cache.
`timescale 1ns/1ps
module ifbm_fetch_master
  import ifbm_pkg::*;
(
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  // Fetch stage request
  input  wire logic                         core_fetch_valid,
  input  wire logic [ADDR_W-1:0]            core_fetch_addr,
  input  wire logic                         core_fetch_cacheable,
  input  wire logic                         core_fetch_user_attr,
  input  wire logic                         core_fetch_touch,
  input  wire logic                         core_cache_hit,
  input  wire logic                         core_flush,
  // Fetch stage answer
  output logic                              core_ready,
  output logic                              core_instr_valid,
  output logic      [WORD_W-1:0]            core_instr_data,
  // Cache line write
  output logic                              cache_wr_en,
  output logic      [TAG_W-1:0]             cache_wr_tag,
  output logic      [LINE_WORDS*WORD_W-1:0] cache_wr_line,
  // Local bus request
  output logic                              fetch_req,
  output logic      [ADDR_W-1:0]            fetch_addr,
  output logic      [1:0]                   line_size,
  output logic                              cacheable_attr,
  output logic                              user_storage_attr,
  output logic      [1:0]                   fetch_priority,
  output logic                              fetch_abort,
  // Local bus response
  input  wire logic                         addr_accept,
  input  wire logic                         slave_width,
  input  wire logic                         read_beat_valid,
  input  wire logic [DATA_W-1:0]            read_data_bus,
  input  wire logic [IDX_W-1:0]             read_word_index,
  input  wire logic                         slave_busy,
  input  wire logic                         slave_error,
  // Register port
  input  wire logic [RADDR_W-1:0]           reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [31:0]                  reg_rdata
);

  ifbm_state_t state_reg;
  ifbm_state_t state_next;
  logic              noncache_line_size_sel_reg;
  logic              no_allocate_fetch_reg;
  logic [1:0]        prio_reg;
  logic              err_reg;
  logic              line_err_reg;
  logic              touch_reg;
  logic              wide_reg;
  logic              tgt_pend_reg;
  logic [3:0]        beats_reg;
  logic [TAG_W-1:0]  tag_reg;
  logic              line_ok_reg;
  logic [WORD_W-1:0] fb_word;
  logic [LINE_WORDS*WORD_W-1:0] fb_line;
  logic [LINE_WORDS-1:0]        fb_valid;
  logic              miss;
  logic              buf_hit;
  logic              issue;
  logic              beat;
  logic              tgt_hit;
  logic              bypass;
  logic              last_beat;
  logic              aborting;
  logic              alloc;
  logic [3:0]        beats_need;
  logic [WORD_W-1:0] tgt_word;

  // Beats expected for the latched size and the width the slave reported.
  function automatic logic [3:0] beats_f(input logic [1:0] sz, input logic wide);
    logic [3:0] n;
    n = BEATS_8W_32;
    case ({sz == SIZE_8W, wide})
      2'h0:    n = BEATS_4W_32;
      2'h1:    n = BEATS_4W_64;
      2'h2:    n = BEATS_8W_32;
      2'h3:    n = BEATS_8W_64;
      default: n = BEATS_8W_32;
    endcase
    return n;
  endfunction

  // Request decode; a buffer hit also counts while the line is still arriving.
  assign miss       = core_fetch_valid && (!core_fetch_cacheable || !core_cache_hit);
  assign buf_hit    = core_fetch_valid && line_ok_reg &&
                      (tag_reg == core_fetch_addr[ADDR_W-1:IDX_W]) &&
                      fb_valid[core_fetch_addr[IDX_W-1:0]];
  assign issue      = (state_reg == ST_IDLE) && miss && !buf_hit && !slave_busy;
  assign beat       = (state_reg == ST_DATA) && read_beat_valid;
  assign beats_need = beats_f(line_size, wide_reg);
  assign last_beat  = beat && (beats_reg + 4'h1 == beats_need);
  assign aborting   = (state_reg == ST_REQ) && core_flush && !addr_accept;
  assign alloc      = cacheable_attr && !line_err_reg && (!no_allocate_fetch_reg || touch_reg);

  // Does this beat carry the target word, and which lane holds it.
  assign tgt_hit  = wide_reg ? (read_word_index[IDX_W-1:1] == fetch_addr[IDX_W-1:1])
                             : (read_word_index == fetch_addr[IDX_W-1:0]);
  assign tgt_word = (wide_reg && fetch_addr[0]) ? read_data_bus[WORD_W-1:0]
                                                : read_data_bus[DATA_W-1:WORD_W];
  assign bypass   = beat && tgt_pend_reg && tgt_hit && !core_flush;

  // Sequencer next state.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (issue) state_next = ST_REQ;
      ST_REQ: begin
        if (addr_accept) state_next = ST_DATA;
        else if (core_flush) state_next = ST_IDLE;
      end
      ST_DATA: if (last_beat) state_next = ST_DONE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // Bus request outputs; read-only master, no write or byte-enable pins exist.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_req         <= 1'b0;
      fetch_addr        <= '0;
      line_size         <= SIZE_4W;
      cacheable_attr    <= 1'b0;
      user_storage_attr <= 1'b0;
      fetch_priority    <= CFG_PRIO_RESET;
      touch_reg         <= 1'b0;
    end else if (issue) begin
      fetch_req         <= 1'b1;
      fetch_addr        <= core_fetch_addr;
      line_size         <= (core_fetch_cacheable || noncache_line_size_sel_reg) ?
                           SIZE_8W : SIZE_4W;
      cacheable_attr    <= core_fetch_cacheable;
      user_storage_attr <= core_fetch_user_attr;
      fetch_priority    <= prio_reg;
      touch_reg         <= core_fetch_touch;
    end else if ((state_reg == ST_REQ) && (addr_accept || core_flush)) begin
      fetch_req <= 1'b0;
    end
  end

  // Abort is a one-cycle pulse, only for a request not yet acknowledged.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) fetch_abort <= 1'b0;
    else fetch_abort <= aborting;
  end

  // Transfer bookkeeping: width, beat count, bypass pending, error.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wide_reg     <= 1'b0;
      beats_reg    <= '0;
      tgt_pend_reg <= 1'b0;
      line_err_reg <= 1'b0;
    end else begin
      if (issue) begin
        beats_reg    <= '0;
        tgt_pend_reg <= 1'b1;
        line_err_reg <= 1'b0;
      end
      if ((state_reg == ST_REQ) && addr_accept) wide_reg <= slave_width;
      if (beat) beats_reg <= beats_reg + 4'h1;
      // Only an error on this line blocks its allocation; the status flag is the sticky one.
      if (beat && slave_error) line_err_reg <= 1'b1;
      // A flush after acknowledge cannot stop the line, but the target is no longer wanted.
      if (bypass || core_flush || (state_reg == ST_DONE)) tgt_pend_reg <= 1'b0;
    end
  end

  // Sticky transfer error; a fresh error wins over a software clear in the same cycle.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) err_reg <= 1'b0;
    else if (beat && slave_error) err_reg <= 1'b1;
    else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_ERR_BIT]) err_reg <= 1'b0;
  end

  // Buffer ownership: a new request claims it, an abort or failed line drops it.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tag_reg     <= '0;
      line_ok_reg <= 1'b0;
    end else if (issue) begin
      tag_reg     <= core_fetch_addr[ADDR_W-1:IDX_W];
      line_ok_reg <= 1'b1;
    end else if (aborting || ((state_reg == ST_DONE) && line_err_reg)) begin
      line_ok_reg <= 1'b0;
    end
  end

  // Fill buffer; the old line lives on until the next request needs the space.
  ifbm_fill_buf u_fill (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .clr       (issue),
    .wr_en     (beat),
    .wr_wide   (wide_reg),
    .wr_idx    (read_word_index),
    .wr_data   (read_data_bus),
    .rd_idx    (core_fetch_addr[IDX_W-1:0]),
    .rd_word   (fb_word),
    .line_flat (fb_line),
    .valid     (fb_valid)
  );

  // Instruction return: bypass of the arriving target beats a buffer hit that cycle.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_instr_valid <= 1'b0;
      core_instr_data  <= '0;
    end else if (bypass) begin
      core_instr_valid <= 1'b1;
      core_instr_data  <= tgt_word;
    end else if (buf_hit && !core_flush) begin
      core_instr_valid <= 1'b1;
      core_instr_data  <= fb_word;
    end else begin
      core_instr_valid <= 1'b0;
    end
  end

  // Ready tells the fetch stage that a miss would be taken now.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) core_ready <= 1'b0;
    else core_ready <= (state_next == ST_IDLE) && !slave_busy;
  end

  // Cache write of a completed line; non-cacheable lines never leave the buffer.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cache_wr_en   <= 1'b0;
      cache_wr_tag  <= '0;
      cache_wr_line <= '0;
    end else begin
      cache_wr_en <= (state_reg == ST_DONE) && alloc;
      if (state_reg == ST_DONE) begin
        cache_wr_tag  <= tag_reg;
        cache_wr_line <= fb_line;
      end
    end
  end

  // Core configuration register.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      noncache_line_size_sel_reg <= 1'b0;
      no_allocate_fetch_reg      <= 1'b0;
      prio_reg                   <= CFG_PRIO_RESET;
    end else if (reg_wr && reg_addr == REG_CORE_CFG) begin
      noncache_line_size_sel_reg <= reg_wdata[CFG_NCSIZE_BIT];
      no_allocate_fetch_reg      <= reg_wdata[CFG_NOFILL_BIT];
      prio_reg <= reg_wdata[CFG_PRIO_LSB +: 2];
    end
  end

  // Read data stand for one cycle only; unmapped offsets read zero.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd && reg_addr == REG_CORE_CFG) begin
        reg_rdata[CFG_NCSIZE_BIT]    <= noncache_line_size_sel_reg;
        reg_rdata[CFG_NOFILL_BIT]    <= no_allocate_fetch_reg;
        reg_rdata[CFG_PRIO_LSB +: 2] <= prio_reg;
      end else if (reg_rd && reg_addr == REG_STATUS) begin
        reg_rdata[ST_BUSY_BIT]                   <= (state_reg != ST_IDLE);
        reg_rdata[ST_ERR_BIT]                    <= err_reg;
        reg_rdata[ST_SLVBSY_BIT]                 <= slave_busy;
        reg_rdata[ST_VALID_LSB +: LINE_WORDS]    <= fb_valid;
      end
    end
  end

  // Checks on the driven behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_issue;
    (state_reg == ST_IDLE) && miss && !buf_hit && !slave_busy;
  endsequence
  sequence s_wait_ack;
    fetch_req && !addr_accept && !core_flush;
  endsequence

  AST_ISSUE_ON_MISS: assert property (s_issue |=> fetch_req && (state_reg == ST_REQ))
    else $error("miss did not raise a fetch request");
  AST_HOLD_REQ: assert property (s_wait_ack |=> fetch_req && $stable(fetch_addr) &&
                                 $stable(line_size) && $stable(cacheable_attr))
    else $error("request outputs changed before acknowledge");
  AST_CACHEABLE_8W: assert property (fetch_req && cacheable_attr |-> line_size == SIZE_8W)
    else $error("cacheable request without eight-word size");
  AST_NC_SIZE: assert property ($rose(fetch_req) && !cacheable_attr |->
                                line_size == ($past(noncache_line_size_sel_reg) ?
                                              SIZE_8W : SIZE_4W))
    else $error("non-cacheable size ignores the size bit");
  AST_ABORT_PULSE: assert property (fetch_abort |-> $past(fetch_req) && !fetch_req &&
                                    !$past(addr_accept) ##1 !fetch_abort)
    else $error("abort not a single pulse after an unacknowledged request");
  AST_BYPASS: assert property (bypass |=> core_instr_valid &&
                               core_instr_data == $past(tgt_word))
    else $error("target beat not forwarded next cycle");
  AST_BUF_HIT: assert property (buf_hit && !bypass && !core_flush |=>
                                core_instr_valid && core_instr_data == $past(fb_word))
    else $error("buffer hit not served next cycle");
  AST_NC_NO_CACHE: assert property (!cacheable_attr && state_reg == ST_DONE |=>
                                    !cache_wr_en)
    else $error("non-cacheable line written to the cache");
  AST_ALLOC: assert property (state_reg == ST_DONE && cacheable_attr && !line_err_reg &&
                              !no_allocate_fetch_reg |=> cache_wr_en)
    else $error("full cacheable line not written");
  AST_TOUCH: assert property (state_reg == ST_DONE && cacheable_attr && !line_err_reg &&
                              touch_reg |=> cache_wr_en)
    else $error("touch line not written despite no-allocate");
  AST_BEATS: assert property (beat |-> beats_reg < beats_need)
    else $error("more beats counted than the line holds");

endmodule

// ==== verif/ifbm_slave_model.sv ====
// Behavioural local-bus slave that answers the line reads of the fetch master.
// Assumes one clock shared with the master; it drives just after rising edges.
`timescale 1ns/1ps
module ifbm_slave_model
  import ifbm_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // Bench controls
  input  wire logic              wide,
  input  wire logic              inj_err,
  input  wire logic [4:0]        ack_wait,
  // Request side
  input  wire logic              fetch_req,
  input  wire logic [ADDR_W-1:0] fetch_addr,
  input  wire logic [1:0]        line_size,
  // Response side
  output logic                   addr_accept,
  output logic                   slave_width,
  output logic                   read_beat_valid,
  output logic      [DATA_W-1:0] read_data_bus,
  output logic      [IDX_W-1:0]  read_word_index,
  output logic                   slave_busy,
  output logic                   slave_error
);
  int                n, t, j;
  logic [ADDR_W-1:0] base;

  // Memory pattern; the bench reckons the same words on its own.
  function automatic logic [WORD_W-1:0] mw(input int x);
    return {2'h0, 30'(x)} ^ 32'h5A5A_0F0F;
  endfunction

  // Accept after a wait, then send the target beat first and the rest downward with wrap,
  // so the master can never rely on a sequential order.
  initial begin
    {addr_accept, slave_width, read_beat_valid, slave_busy} = 4'h0;
    slave_error = 1'b0;
    read_data_bus = 64'h0;
    read_word_index = 3'h0;
    forever begin
      @(posedge ref_clk);
      if (!sys_rst && fetch_req === 1'b1) begin
        repeat (ack_wait) @(posedge ref_clk);
        if (fetch_req === 1'b1) begin
          addr_accept <= 1'b1;
          slave_width <= wide;
          slave_busy <= 1'b1;
          n = (line_size == SIZE_8W) ? 8 : 4;
          base = (n == 8) ? {fetch_addr[29:3], 3'h0} : {fetch_addr[29:2], 2'h0};
          n = wide ? n / 2 : n;
          t = (wide ? int'(fetch_addr[2:1]) : int'(fetch_addr[2:0])) & (n - 1);
          @(posedge ref_clk);
          addr_accept <= 1'b0;
          for (int i = 0; i < n; i++) begin
            j = (t - i) & (n - 1);
            read_beat_valid <= 1'b1;
            read_word_index <= base[2:0] + (wide ? 3'(2 * j) : 3'(j));
            read_data_bus <= wide ? {mw(base + 2 * j), mw(base + 2 * j + 1)}
                                  : {mw(base + j), ~mw(base + j)};
            slave_error <= inj_err && (i == n - 1);
            @(posedge ref_clk);
          end
          // Released lines flip, so stale data can never pass for a beat.
          read_beat_valid <= 1'b0;
          slave_error <= 1'b0;
          slave_busy <= 1'b0;
          read_data_bus <= ~read_data_bus;
          read_word_index <= ~read_word_index;
        end
      end
    end
  end
endmodule

// ==== verif/instruction_fetch_bus_master_test.sv ====
// Self-checking bench for the instruction fetch bus master and a behavioural slave.
// Assumes one 200 MHz clock; all inputs move by non-blocking assignment at rising edges.
`timescale 1ns/1ps
module instruction_fetch_bus_master_test;
  import ifbm_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic core_fetch_valid, core_fetch_cacheable, core_fetch_user_attr, core_fetch_touch;
  logic core_cache_hit, core_flush, reg_wr, reg_rd, core_ready, core_instr_valid;
  logic cache_wr_en, fetch_req, cacheable_attr, user_storage_attr, fetch_abort;
  logic addr_accept, slave_width, read_beat_valid, slave_busy, slave_error, wide, inj_err;
  logic [1:0] line_size, fetch_priority;
  logic [2:0] read_word_index;
  logic [3:0] reg_addr;
  logic [4:0] ack_wait;
  logic [26:0] cache_wr_tag;
  logic [29:0] core_fetch_addr, fetch_addr, a;
  logic [31:0] reg_wdata, reg_rdata, core_instr_data;
  logic [63:0] read_data_bus;
  logic [255:0] cache_wr_line;
  logic [31:0] exp_q[$];
  int n_mismatch = 0, n_compared = 0, seed = 91198, n_wr;

  ifbm_fetch_master u_ifbm_fetch_master (.ref_clk, .sys_rst, .core_fetch_valid,
    .core_fetch_addr, .core_fetch_cacheable, .core_fetch_user_attr, .core_fetch_touch,
    .core_cache_hit, .core_flush, .core_ready, .core_instr_valid, .core_instr_data,
    .cache_wr_en, .cache_wr_tag, .cache_wr_line, .fetch_req, .fetch_addr, .line_size,
    .cacheable_attr, .user_storage_attr, .fetch_priority, .fetch_abort, .addr_accept,
    .slave_width, .read_beat_valid, .read_data_bus, .read_word_index, .slave_busy,
    .slave_error, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  ifbm_slave_model u_ifbm_slave_model (.ref_clk, .sys_rst, .wide, .inj_err, .ack_wait,
    .fetch_req, .fetch_addr, .line_size, .addr_accept, .slave_width, .read_beat_valid,
    .read_data_bus, .read_word_index, .slave_busy, .slave_error);

  // Clock of 5 ns period.
  always #2.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] mw(input logic [29:0] x);
    return {2'h0, x} ^ 32'h5A5A_0F0F;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask

  // One register cycle; after a read the data stand when this returns.
  task automatic reg_op(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask

  // A fetch is seen only in the cycle it is presented, so the address is scrambled after.
  task automatic fetch(input logic [29:0] ad, input logic c, input logic t, input logic h);
    @(posedge ref_clk);
    core_fetch_valid <= 1'b1;
    core_fetch_addr <= ad;
    core_fetch_cacheable <= c;
    core_fetch_user_attr <= ad[4];
    core_fetch_touch <= t;
    core_cache_hit <= h;
    @(posedge ref_clk);
    core_fetch_valid <= 1'b0;
    core_fetch_addr <= 30'($random(seed));
    #1;
  endtask

  // Watches a whole line transfer against the queue of expected instructions.
  task automatic collect(input logic [29:0] ad);
    n_wr = 0;
    repeat (40) begin
      tick();
      if (core_instr_valid === 1'b1)
        chk(core_instr_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x, "bypass");
      if (cache_wr_en === 1'b1) begin
        n_wr++;
        chk(32'(cache_wr_tag), 32'(ad[29:3]), "tag");
        for (int i = 0; i < 8; i++)
          chk(cache_wr_line[32*i+:32], mw({ad[29:3], 3'(i)}), "line");
      end
    end
    chk(32'(exp_q.size()), 32'h0, "missing instr");
  endtask

  // Main sequence.
  initial begin
    {core_fetch_valid, core_fetch_cacheable, core_fetch_user_attr, core_fetch_touch} = 4'h0;
    {core_cache_hit, core_flush, reg_wr, reg_rd, wide, inj_err} = 6'h00;
    {core_fetch_addr, reg_addr, reg_wdata, ack_wait} = '0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    tick();
    chk(32'({fetch_req, line_size, core_ready}), 32'h3, "reset outputs");
    reg_op(1'b0, REG_CORE_CFG, 32'h0);
    chk(reg_rdata, 32'h0, "cfg reset");
    reg_op(1'b0, 4'h8, 32'h0);
    chk(reg_rdata, 32'h0, "unmapped");
    for (int k = 0; k < 8; k++) begin
      reg_op(1'b1, REG_CORE_CFG, 32'({k[1:0], k[1], k[1] ^ k[2]}));
      reg_op(1'b0, REG_CORE_CFG, 32'h0);
      chk(32'(reg_rdata[3:0]), 32'({k[1:0], k[1], k[1] ^ k[2]}), "cfg");
      wide <= k[1];
      ack_wait <= 5'($random(seed)) & 5'h3;
      a = 30'($random(seed));
      exp_q.push_back(mw(a));
      fetch(a, k[0], k[2], 1'b0);
      chk(32'({fetch_req, core_ready}), 32'h2, "miss");
      chk(32'(line_size), 32'((k[0] | (k[1] ^ k[2])) ? SIZE_8W : SIZE_4W), "size");
      chk(32'({cacheable_attr, user_storage_attr, fetch_priority}),
          32'({k[0], a[4], k[1:0]}), "attrs");
      chk(32'(fetch_addr), 32'(a), "addr");
      collect(a);
      chk(32'(n_wr), 32'(k[0] & (!k[1] | k[2])), "allocate");
      fetch(a ^ 30'h1, k[0], 1'b0, 1'b0);
      chk(32'({fetch_req, core_instr_valid}), 32'h1, "buffer hit");
      chk(core_instr_data, mw(a ^ 30'h1), "hit data");
    end
    // A line with a beat error still bypasses its target but must not be allocated.
    reg_op(1'b1, REG_CORE_CFG, 32'h0);
    inj_err <= 1'b1;
    a = 30'($random(seed));
    exp_q.push_back(mw(a));
    fetch(a, 1'b1, 1'b0, 1'b0);
    collect(a);
    chk(32'(n_wr), 32'h0, "error line");
    reg_op(1'b0, REG_STATUS, 32'h0);
    chk(32'(reg_rdata[ST_ERR_BIT]), 32'h1, "error flag");
    reg_op(1'b1, REG_STATUS, 32'h2);
    inj_err <= 1'b0;
    ack_wait <= 5'h14;
    fetch(30'($random(seed)), 1'b1, 1'b0, 1'b0);
    @(posedge ref_clk);
    core_flush <= 1'b1;
    @(posedge ref_clk);
    core_flush <= 1'b0;
    #1;
    chk(32'(fetch_abort), 32'h1, "abort");
    tick();
    chk(32'({fetch_abort, fetch_req}), 32'h0, "after abort");
    repeat (25) tick();
    fetch(30'($random(seed)), 1'b1, 1'b0, 1'b1);
    chk(32'(fetch_req), 32'h0, "cache hit");
    reg_op(1'b0, REG_STATUS, 32'h0);
    chk(32'(reg_rdata[ST_SLVBSY_BIT:ST_BUSY_BIT]), 32'h0, "idle status");
    results();
  end

  // Watchdog far beyond the expected run of under a thousand cycles.
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule
